/* src/exc_entry_pkg.sv */
// Shared constants and types of the reset, break and interrupt entry unit.
// Assumes a 32-bit core, word registers on an AHB-Lite slave and a 25 MHz hclk.
package exc_entry_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] STATUS_OFS       = 8'h00;
  localparam logic [7:0] BREAK_SAVED_OFS  = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFS     = 8'h08;
  localparam logic [7:0] IRQ_WAITING_OFS  = 8'h0C;
  localparam logic [7:0] CONFIG_OFS       = 8'h10;
  localparam logic [7:0] BREAK_RETURN_OFS = 8'h14;
  localparam logic [7:0] REG_ZERO_OFS     = 8'h18;
  localparam logic [7:0] UNIT_STATE_OFS   = 8'h1C;

  // Register file slot written on break entry and shadow set holding it
  localparam logic [4:0] BREAK_RETURN_GPR = 5'h1E;
  localparam logic [5:0] NORMAL_SET       = 6'h00;
  localparam logic [31:0] INSTR_BYTES     = 32'h0000_0004;

  // Bit position of auto_nesting_flag in the configuration register
  localparam int AUTO_NEST_POS = 0;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef struct packed {
    logic [8:0] reserved;
    logic       reset_int_enable_field;
    logic       nmi_active;
    logic [5:0] prior_shadow_set;
    logic [5:0] active_shadow_set;
    logic [5:0] current_irq_level;
    logic       exception_handling_flag;
    logic       privilege_level_bit;
    logic       global_int_enable;
  } status_s;

  localparam status_s STATUS_RESET = '{reset_int_enable_field: 1'b1, default: '0};

  // Request bundle from the outside_vector_controller
  typedef struct packed {
    logic        request;
    logic        nonmaskable_request_flag;
    logic [5:0]  requested_priority;
    logic [5:0]  requested_shadow_set;
    logic [31:0] handler_target_vector;
  } ext_req_s;

  // Redirect of the fetch unit
  typedef struct packed {
    logic        valid;
    logic        virt;
    logic [31:0] addr;
  } redirect_s;

  typedef enum logic [1:0] {
    ST_INVAL,
    ST_LAUNCH,
    ST_RUN
  } unit_state_e;

endpackage

/* src/pin_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous pins.
// Multi-bit bundles must be held stable by the sender while they are sampled.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

/* src/exc_entry.sv */
// Reset sequence, break entry and return, and interrupt acceptance of the core.
// Assumes the core signals break and return instructions as one-cycle pulses on hclk,
// and that the hardware break, IRQ lines and controller bundle are asynchronous pins.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - Reset sets reset_int_enable_field and clears all other status fields.
// RULE_02 - Reset invalidates the reset vector cache line, then fetches at the reset vector.
// RULE_03 - Register zero reads zero; other registers have no defined reset value.
// RULE_04 - Nonmaskable requests are accepted during reset or break handling.
// RULE_05 - Break entry first copies status into break_saved_state.
// RULE_06 - Break entry clears global_int_enable.
// RULE_07 - Break entry writes the following instruction address into register 30.
// RULE_08 - Break entry clears privilege_level_bit when an MMU or MPU exists.
// RULE_09 - Break entry sets exception_handling_flag when an MMU exists.
// RULE_10 - Break entry copies active into prior shadow set, then selects set zero.
// RULE_11 - Break entry then redirects execution to the break vector.
// RULE_12 - Break instruction or debug hardware break enters break, even inside exceptions.
// RULE_13 - Return from debug restores status and resumes at break_return_addr.
// RULE_14 - The outside controller presents vector, priority, set and nonmaskable flag.
// RULE_15 - With an MMU the handler_target_vector is a virtual address.
// RULE_16 - Maskable external requests need requested_priority above current_irq_level.
// RULE_17 - Nonmaskable requests ignore requested_priority and current_irq_level.
// RULE_18 - With shadow sets, accepting switches to requested_shadow_set.
// RULE_19 - Acceptance clears global_int_enable unless auto_nesting_flag is one.
// RULE_20 - Internal controller takes 32 lines gated by enable and mask, clears enable.
// RULE_21 - irq_waiting_reg shows which request lines are pending.
// RULE_22 - Peripherals hold requests until the processor responds.
// RULE_23 - irq_waiting_reg is request AND irq_mask_reg, each clock cycle.
module exc_entry
  import exc_entry_pkg::*;
#(
  parameter int          IRQ_LINES     = 32,
  parameter bit          USE_EXT_CTRL  = 1'b0,
  parameter bit          HAS_MMU       = 1'b0,
  parameter bit          HAS_MPU       = 1'b0,
  parameter int          SHADOW_SETS   = 0,
  parameter logic [31:0] RESET_VECTOR  = 32'h0000_0000,
  parameter logic [31:0] BREAK_VECTOR  = 32'h0000_0020,
  parameter logic [31:0] GENERAL_VECTOR = 32'h0000_0040
) (
  // Clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic [31:0]                   hrdata,
  output logic                          hresp,
  // Core pipeline events, same clock
  input  wire logic                     break_instr,
  input  wire logic [31:0]              break_instr_pc,
  input  wire logic                     return_from_debug_instr,
  input  wire logic [31:0]              resume_pc,
  // Asynchronous pins
  input  wire logic                     debug_hw_break,
  input  wire logic [IRQ_LINES-1:0]     irq_in,
  input  wire exc_entry_pkg::ext_req_s  ext_req,
  // Fetch unit and cache
  output exc_entry_pkg::redirect_s      redirect,
  output logic                          icache_line_inval,
  output logic [31:0]                   icache_inval_addr,
  // Register file write of the break return address
  output logic                          gpr_we,
  output logic [4:0]                    gpr_waddr,
  output logic [5:0]                    gpr_wset,
  output logic [31:0]                   gpr_wdata,
  // Status seen by the core and interrupt acknowledge
  output exc_entry_pkg::status_s        status_out,
  output logic                          irq_taken
);

  unit_state_e          state;
  status_s              status;
  status_s              break_saved_state;
  logic [31:0]          break_return_addr;
  logic [IRQ_LINES-1:0] irq_mask_reg;
  logic [IRQ_LINES-1:0] irq_waiting_reg;
  logic                 auto_nesting_flag;

  logic [IRQ_LINES-1:0] irq_sync;
  logic                 hw_break_sync;
  logic                 hw_break_prev;
  ext_req_s             ext_sync;

  logic                 wr_pend;
  logic [7:0]           wr_ofs;
  logic                 addr_ok;
  logic [31:0]          next_rdata;

  logic                 break_event;
  logic [31:0]          break_next_pc;
  logic                 int_take;
  logic [31:0]          int_vector;
  logic                 int_nmi;
  logic [5:0]           int_level;
  logic [5:0]           int_set;
  logic                 sw_write_status;

  // Pin synchronisers
  pin_sync #(.WIDTH(IRQ_LINES)) u_irq_sync (
    .hclk(hclk), .hresetn(hresetn), .d(irq_in), .q(irq_sync));

  pin_sync #(.WIDTH(1)) u_brk_sync (
    .hclk(hclk), .hresetn(hresetn), .d(debug_hw_break), .q(hw_break_sync));

  pin_sync #(.WIDTH($bits(ext_req_s))) u_ext_sync (
    .hclk(hclk), .hresetn(hresetn), .d(ext_req), .q(ext_sync));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hw_break_prev <= 1'b0;
    end else begin
      hw_break_prev <= hw_break_sync;
    end
  end

  // Break sources: software instruction or rising debug line, only in state ST_RUN
  always_comb begin
    break_event   = (state == ST_RUN) && (break_instr || (hw_break_sync && !hw_break_prev)); // RULE_12
    break_next_pc = break_instr ? (break_instr_pc + INSTR_BYTES) : resume_pc; // RULE_07
  end

  // Interrupt decision
  always_comb begin
    int_take   = 1'b0;
    int_vector = GENERAL_VECTOR;
    int_nmi    = 1'b0;
    int_level  = status.current_irq_level;
    int_set    = status.active_shadow_set;
    if (USE_EXT_CTRL) begin
      int_vector = ext_sync.handler_target_vector;
      int_nmi    = ext_sync.nonmaskable_request_flag;
      int_level  = ext_sync.requested_priority;
      if (SHADOW_SETS > 0) begin
        int_set = ext_sync.requested_shadow_set; // RULE_18
      end
      if (ext_sync.request) begin
        if (ext_sync.nonmaskable_request_flag) begin
          int_take = !status.nmi_active; // RULE_17 RULE_04
        end else begin
          int_take = status.global_int_enable
                     && (ext_sync.requested_priority > status.current_irq_level); // RULE_16
        end
      end
    end else begin
      int_take = status.global_int_enable && (|irq_waiting_reg); // RULE_20
    end
    // Nonmaskable requests are held off only while nmi_active is set, in ST_INVAL of the reset sequence and in a break_event or return cycle
    if (state == ST_INVAL || (state != ST_RUN && !int_nmi)
        || break_event || return_from_debug_instr) begin
      int_take = 1'b0;
    end
  end

  // Reset sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_INVAL;
    end else begin
      unique case (state)
        ST_INVAL:  state <= ST_LAUNCH;
        ST_LAUNCH: state <= ST_RUN;
        ST_RUN:    state <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      icache_line_inval <= 1'b0;
      icache_inval_addr <= 32'h0000_0000;
    end else begin
      icache_line_inval <= (state == ST_INVAL); // RULE_02
      icache_inval_addr <= RESET_VECTOR;
    end
  end

  // Fetch redirect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      redirect <= '0;
    end else begin
      redirect <= '0;
      if (state == ST_LAUNCH && !int_take) begin
        redirect.valid <= 1'b1;
        redirect.addr  <= RESET_VECTOR; // RULE_02
      end else if (break_event) begin
        redirect.valid <= 1'b1;
        redirect.addr  <= BREAK_VECTOR; // RULE_11
      end else if (return_from_debug_instr) begin
        redirect.valid <= 1'b1;
        redirect.addr  <= break_return_addr; // RULE_13
      end else if (int_take) begin
        redirect.valid <= 1'b1;
        redirect.addr  <= int_vector;
        redirect.virt  <= USE_EXT_CTRL && HAS_MMU; // RULE_15
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_taken <= 1'b0;
    end else begin
      irq_taken <= int_take;
    end
  end

  // Register 30 of the normal set receives the return address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpr_we    <= 1'b0;
      gpr_waddr <= BREAK_RETURN_GPR;
      gpr_wset  <= NORMAL_SET;
      gpr_wdata <= 32'h0000_0000;
    end else begin
      gpr_we    <= break_event; // RULE_07
      gpr_waddr <= BREAK_RETURN_GPR;
      gpr_wset  <= NORMAL_SET;
      gpr_wdata <= break_next_pc;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      break_return_addr <= 32'h0000_0000;
    end else if (break_event) begin
      break_return_addr <= break_next_pc; // RULE_07
    end
  end

  // Saved status: hardware capture wins over a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      break_saved_state <= '0;
    end else if (break_event) begin
      break_saved_state <= status; // RULE_05
    end else if (wr_pend && wr_ofs == BREAK_SAVED_OFS) begin
      break_saved_state <= status_s'(hwdata);
    end
  end

  // Status register
  always_comb begin
    sw_write_status = wr_pend && (wr_ofs == STATUS_OFS);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= STATUS_RESET; // RULE_01
    end else if (break_event) begin
      status.global_int_enable <= 1'b0; // RULE_06
      if (HAS_MMU || HAS_MPU) begin
        status.privilege_level_bit <= 1'b0; // RULE_08
      end
      if (HAS_MMU) begin
        status.exception_handling_flag <= 1'b1; // RULE_09
      end
      status.prior_shadow_set  <= status.active_shadow_set; // RULE_10
      status.active_shadow_set <= NORMAL_SET; // RULE_10
    end else if (return_from_debug_instr) begin
      status <= break_saved_state; // RULE_13
    end else if (int_take) begin
      status.global_int_enable <= status.global_int_enable && auto_nesting_flag
                                  && USE_EXT_CTRL; // RULE_19 RULE_20
      if (int_nmi) begin
        status.nmi_active <= 1'b1;
      end else if (USE_EXT_CTRL) begin
        status.current_irq_level <= int_level;
      end
      if (USE_EXT_CTRL && SHADOW_SETS > 0) begin
        status.prior_shadow_set  <= status.active_shadow_set;
        status.active_shadow_set <= int_set; // RULE_18
      end
    end else if (sw_write_status) begin
      status          <= status_s'(hwdata);
      status.reserved <= '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_out <= STATUS_RESET;
    end else begin
      status_out <= status;
    end
  end

  // Internal controller mask and pending lines
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_reg <= '0;
    end else if (wr_pend && wr_ofs == IRQ_MASK_OFS) begin
      irq_mask_reg <= hwdata[IRQ_LINES-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_waiting_reg <= '0;
    end else begin
      irq_waiting_reg <= irq_sync & irq_mask_reg; // RULE_21 RULE_23 RULE_22
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_nesting_flag <= 1'b0;
    end else if (wr_pend && wr_ofs == CONFIG_OFS) begin
      auto_nesting_flag <= hwdata[AUTO_NEST_POS]; // RULE_19
    end
  end

  // AHB-Lite slave: zero wait states, read data registered from the address phase
  always_comb begin
    addr_ok    = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      STATUS_OFS:       next_rdata = status;
      BREAK_SAVED_OFS:  next_rdata = break_saved_state;
      IRQ_MASK_OFS:     next_rdata[IRQ_LINES-1:0] = irq_mask_reg;
      IRQ_WAITING_OFS:  next_rdata[IRQ_LINES-1:0] = irq_waiting_reg;
      CONFIG_OFS:       next_rdata[AUTO_NEST_POS] = auto_nesting_flag;
      BREAK_RETURN_OFS: next_rdata = break_return_addr;
      REG_ZERO_OFS:     next_rdata = 32'h0000_0000; // RULE_03
      UNIT_STATE_OFS:   next_rdata[1:0] = state;
      default:          next_rdata = 32'h0000_0000;
    endcase
    if (haddr[31:8] != 24'h00_0000) begin
      next_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_ofs  <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite && (haddr[31:8] == 24'h00_0000);
      wr_ofs  <= haddr[7:0];
    end
  end

  // Bus answer: always ready and OKAY, read data held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
      if (addr_ok && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

endmodule

/* bench/irq_source_model.sv */
// Peripheral model that drives the interrupt request lines of the unit.
// Assumes the bench raises and services lines with one-cycle masks on hclk.
`timescale 1ns/1ps
module irq_source_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Bench commands
  input  wire logic [31:0] raise,
  input  wire logic [31:0] service,
  // Request lines
  output logic      [31:0] irq
);
  // A line stays up until its peripheral is serviced
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 32'h0000_0000;
    end else begin
      irq <= (irq | raise) & ~service;
    end
  end
endmodule

/* bench/exc_entry_sva.sv */
// Checker for the reset, break and interrupt entry unit.
// Bound to exc_entry; sees only its ports; one clock domain.
`timescale 1ns/1ps
module exc_entry_sva
  import exc_entry_pkg::*;
#(
  parameter logic [31:0] RESET_VECTOR   = 32'h0000_0000,
  parameter logic [31:0] BREAK_VECTOR   = 32'h0000_0020,
  parameter logic [31:0] GENERAL_VECTOR = 32'h0000_0040,
  parameter bit          USE_EXT_CTRL   = 1'b0,
  parameter bit          HAS_MMU        = 1'b0
) (
  // Clock, reset and bus
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    hsel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [2:0]              hsize,
  input wire logic                    hready,
  input wire logic [31:0]             hrdata,
  // Core events and outputs
  input wire logic                    break_instr,
  input wire logic [31:0]             break_instr_pc,
  input wire logic                    return_from_debug_instr,
  input wire exc_entry_pkg::redirect_s redirect,
  input wire logic                    icache_line_inval,
  input wire logic [31:0]             icache_inval_addr,
  input wire logic                    gpr_we,
  input wire logic [4:0]              gpr_waddr,
  input wire logic [5:0]              gpr_wset,
  input wire logic [31:0]             gpr_wdata,
  input wire exc_entry_pkg::status_s  status_out,
  input wire logic                    irq_taken
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_rst_status;
    !$past(hresetn) |-> status_out == STATUS_RESET;
  endproperty
  a_rst_status: assert property (p_rst_status) else $error("status not reset");
  property p_inval_then_fetch;
    icache_line_inval |-> icache_inval_addr == RESET_VECTOR
      ##1 (redirect.valid && redirect.addr == RESET_VECTOR);
  endproperty
  a_inval_then_fetch: assert property (p_inval_then_fetch) else $error("reset fetch");
  property p_zero_reads_zero;
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && hsize == HSIZE_WORD
      && haddr[7:0] == REG_ZERO_OFS |=> hrdata == 32'h0000_0000;
  endproperty
  a_zero_reads_zero: assert property (p_zero_reads_zero) else $error("zero reg");
  property p_brk_ret_addr;
    break_instr |=> gpr_we && gpr_waddr == BREAK_RETURN_GPR && gpr_wset == NORMAL_SET
      && gpr_wdata == $past(break_instr_pc) + INSTR_BYTES;
  endproperty
  a_brk_ret_addr: assert property (p_brk_ret_addr) else $error("return address");
  property p_brk_status;
    break_instr |-> ##[1:2] (!status_out.global_int_enable && status_out.active_shadow_set == 0);
  endproperty
  a_brk_status: assert property (p_brk_status) else $error("break status");
  property p_brk_vector;
    break_instr |=> redirect.valid && redirect.addr == BREAK_VECTOR;
  endproperty
  a_brk_vector: assert property (p_brk_vector) else $error("break vector");
  property p_ret_resume;
    return_from_debug_instr && !break_instr |=> redirect.valid;
  endproperty
  a_ret_resume: assert property (p_ret_resume) else $error("no resume");
  property p_irq_disable;
    irq_taken && !USE_EXT_CTRL |-> ##[1:2] !status_out.global_int_enable;
  endproperty
  a_irq_disable: assert property (p_irq_disable) else $error("enable kept");
  property p_irq_vector;
    irq_taken |-> redirect.valid && (USE_EXT_CTRL ? redirect.virt == HAS_MMU
      : (redirect.addr == GENERAL_VECTOR && !redirect.virt));
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("irq vector");

  c_break: cover property (break_instr ##1 gpr_we);
  c_return: cover property (return_from_debug_instr ##1 redirect.valid);
  c_irq: cover property (irq_taken);
endmodule
bind exc_entry exc_entry_sva #(
  .RESET_VECTOR   (RESET_VECTOR),
  .BREAK_VECTOR   (BREAK_VECTOR),
  .GENERAL_VECTOR (GENERAL_VECTOR),
  .USE_EXT_CTRL   (USE_EXT_CTRL),
  .HAS_MMU        (HAS_MMU)
) sva_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata),
  .break_instr(break_instr), .break_instr_pc(break_instr_pc),
  .return_from_debug_instr(return_from_debug_instr), .redirect(redirect),
  .icache_line_inval(icache_line_inval), .icache_inval_addr(icache_inval_addr),
  .gpr_we(gpr_we), .gpr_waddr(gpr_waddr), .gpr_wset(gpr_wset), .gpr_wdata(gpr_wdata),
  .status_out(status_out), .irq_taken(irq_taken)
);

/* bench/reset_break_interrupt_entry_tb.sv */
// Self-checking bench of exc_entry with the internal and the outside interrupt controller.
// Assumes an AHB-Lite master here and the peripheral model on the IRQ lines.
`timescale 1ns/1ps
module reset_break_interrupt_entry_tb;
  import exc_entry_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, brk, ret, hwbrk, irq_taken;
  logic [31:0] haddr, hwdata, hrdata, pc, rpc, irq, raise, service;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int err_total, samples_checked, cyc, irq_cnt, ext_cnt;
  logic ex_taken, ext_virt;
  logic [31:0] ext_addr;
  ext_req_s ext;
  redirect_s ex_redir;
  status_s ex_st;
  localparam logic [31:0] S0 = 32'h0040_0603;
  assign hready = hreadyout;

  exc_entry dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .break_instr(brk),
    .break_instr_pc(pc), .return_from_debug_instr(ret), .resume_pc(rpc),
    .debug_hw_break(hwbrk), .irq_in(irq), .ext_req('0), .redirect(), .icache_line_inval(),
    .icache_inval_addr(), .gpr_we(), .gpr_waddr(), .gpr_wset(), .gpr_wdata(),
    .status_out(), .irq_taken(irq_taken));
  irq_source_model periph_u (.hclk(hclk), .hresetn(hresetn), .raise(raise),
    .service(service), .irq(irq));
  // Outside controller variant with an MMU and shadow sets, sharing the bus and core events
  exc_entry #(.USE_EXT_CTRL(1'b1), .HAS_MMU(1'b1), .SHADOW_SETS(4)) dut_ext_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(),
    .hrdata(), .hresp(), .break_instr(brk), .break_instr_pc(pc),
    .return_from_debug_instr(ret), .resume_pc(rpc), .debug_hw_break(hwbrk),
    .irq_in(32'h0000_0000), .ext_req(ext), .redirect(ex_redir), .icache_line_inval(),
    .icache_inval_addr(), .gpr_we(), .gpr_waddr(), .gpr_wset(), .gpr_wdata(),
    .status_out(ex_st), .irq_taken(ex_taken));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= HTRANS_NONSEQ; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    ahb(1'b0, a, 32'h0, v);
  endtask
  task automatic pulse(input logic is_ret);
    @(posedge hclk);
    if (is_ret) ret <= 1'b1; else brk <= 1'b1;
    @(posedge hclk);
    ret <= 1'b0; brk <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  task automatic t_reset();
    logic [31:0] v;
    rd(STATUS_OFS, v); chk("status", v, STATUS_RESET);
    rd(UNIT_STATE_OFS, v); chk("state", v, 32'h0000_0002);
    wr(REG_ZERO_OFS, 32'hFFFF_FFFF);
    rd(REG_ZERO_OFS, v); chk("zero", v, 32'h0000_0000);
    rd(8'h40, v); chk("unmapped", v, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_break();
    logic [31:0] v;
    wr(IRQ_MASK_OFS, 32'h0000_0000);
    wr(STATUS_OFS, S0);
    pc <= 32'h0000_0100;
    pulse(1'b0);
    rd(BREAK_SAVED_OFS, v); chk("saved", v, S0);
    rd(STATUS_OFS, v); chk("brk status", v, 32'h0041_8002);
    chk("mmu brk status", ex_st, 32'h0041_8004);
    rd(BREAK_RETURN_OFS, v); chk("ret addr", v, 32'h0000_0104);
    pulse(1'b1);
    rd(STATUS_OFS, v); chk("restored", v, S0);
    rpc <= 32'h0000_0200; hwbrk <= 1'b1;
    repeat (6) @(posedge hclk);
    hwbrk <= 1'b0;
    rd(BREAK_RETURN_OFS, v); chk("hw ret", v, 32'h0000_0200);
    rd(BREAK_SAVED_OFS, v); chk("hw saved", v, S0);
    $display("test break done");
  endtask
  task automatic t_irq();
    logic [31:0] v;
    wr(STATUS_OFS, 32'h0040_0000);
    wr(IRQ_MASK_OFS, 32'h0000_0005);
    @(posedge hclk) raise <= 32'h0000_0003;
    @(posedge hclk) raise <= 32'h0;
    repeat (6) @(posedge hclk);
    rd(IRQ_WAITING_OFS, v); chk("waiting", v, 32'h0000_0001);
    chk("no take", irq_cnt, 0);
    wr(STATUS_OFS, 32'h0040_0001);
    for (int i = 0; i < 20 && irq_cnt == 0; i++) @(posedge hclk);
    chk("taken", irq_cnt, 1);
    rd(STATUS_OFS, v); chk("pie", {31'h0, v[0]}, 32'h0);
    @(posedge hclk) service <= 32'h0000_0001;
    @(posedge hclk) service <= 32'h0;
    repeat (6) @(posedge hclk);
    rd(IRQ_WAITING_OFS, v); chk("cleared", v, 32'h0000_0000);
    chk("once", irq_cnt, 1);
    $display("test irq done");
  endtask
  task automatic t_ext();
    wr(STATUS_OFS, 32'h0040_0019);
    ext <= '{1'b1, 1'b0, 6'h03, 6'h02, 32'h0000_1000};
    repeat (6) @(posedge hclk);
    chk("low prio", ext_cnt, 0);
    ext.requested_priority <= 6'h04;
    for (int i = 0; i < 20 && ext_cnt == 0; i++) @(posedge hclk);
    repeat (2) @(posedge hclk);
    chk("high prio", ext_cnt, 1);
    chk("vector", ext_addr, 32'h0000_1000);
    chk("virtual", {31'h0, ext_virt}, 32'h0000_0001);
    chk("ext status", ex_st, 32'h0040_0420);
    ext <= '0;
    wr(CONFIG_OFS, 32'h0000_0001);
    wr(STATUS_OFS, 32'h0040_0001);
    ext <= '{1'b1, 1'b0, 6'h05, 6'h01, 32'h0000_1800};
    for (int i = 0; i < 20 && ext_cnt == 1; i++) @(posedge hclk);
    repeat (2) @(posedge hclk);
    chk("nested", ext_cnt, 2);
    chk("nest status", ex_st, 32'h0040_0229);
    pulse(1'b0);
    ext <= '{1'b1, 1'b1, 6'h00, 6'h03, 32'h0000_2000};
    for (int i = 0; i < 20 && ext_cnt == 2; i++) @(posedge hclk);
    repeat (6) @(posedge hclk);
    chk("nmi", ext_cnt, 3);
    chk("nmi vector", ext_addr, 32'h0000_2000);
    chk("nmi status", ex_st, 32'h0060_062C);
    ext <= '0;
    $display("test ext done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    hclk = 0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (irq_taken === 1'b1) irq_cnt++;
    if (ex_taken === 1'b1) begin
      ext_cnt++;
      ext_addr = ex_redir.addr;
      ext_virt = ex_redir.virt;
    end
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, brk, ret, hwbrk} = '0;
    {haddr, hwdata, pc, rpc, raise, service} = '0;
    htrans = 2'h0; hsize = HSIZE_WORD;
    ext = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_reset();
    t_break();
    t_irq();
    t_ext();
    finish_test();
  end
endmodule
